//--- hw/urdc_regs.svh
`ifndef URDC_REGS_SVH
`define URDC_REGS_SVH
// word addresses, one 32-bit word per register
`define URDC_CH0_DEF_ADDR 4'h0
`define URDC_CH0_CSR_ADDR 4'h1
`define URDC_CH1_DEF_ADDR 4'h2
`define URDC_CH1_CSR_ADDR 4'h3
`define URDC_IRQ_STATUS_ADDR 4'h4
`define URDC_IRQ_ENABLE_ADDR 4'h5
`define URDC_IRQ_CLEAR_ADDR 4'h6
// definition register fields
`define URDC_DEF_EN_BIT 7
`define URDC_DEF_IE_BIT 6
`define URDC_DEF_CONT_BIT 5
`define URDC_DEF_BUFSEL_BIT 4
`define URDC_DEF_PROT_BIT 3
`define URDC_DEF_RESET 8'h00
// control/status fields
`define URDC_CSR_TEN_BIT 7
`define URDC_CSR_TO_MSB 6
`define URDC_CSR_TO_LSB 2
`define URDC_CSR_FLAG_BIT 1
`define URDC_CSR_RESET 8'h00
// interrupt status layout: bit 2*ch completion, bit 2*ch+1 timeout
`define URDC_IRQ_BITS 4
`define URDC_SOF_PERIOD_MS 1
`endif

//--- hw/urdc_pkg.sv
package urdc_pkg;
  typedef struct packed {
    logic enable;
    logic irqEnable;
    logic continuous;
    logic bufferSelect;
    logic [2:0] endpointPtr;
  } urdc_def_t;

  typedef struct packed {
    logic counterEnable;
    logic [4:0] timeoutValue;
    logic timeoutFlag;
  } urdc_csr_t;

  // request from the uart side for one channel
  typedef struct packed {
    logic byteValid;
    logic rxError;
    logic byteCountZero;
  } urdc_rx_t;

  // descriptor update toward the buffer manager
  typedef struct packed {
    logic update;
    logic nakClear;
    logic [2:0] endpointPtr;
    logic bufferSelect;
  } urdc_desc_t;

  typedef enum logic [2:0] {
    URDC_IDLE = 3'b001,
    URDC_RUN = 3'b010,
    URDC_HALT = 3'b100
  } urdc_state_t;
endpackage : urdc_pkg

//--- hw/urdc_channel.sv
`timescale 1ns/10ps
`default_nettype none
`include "urdc_regs.svh"
module urdc_channel
(
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic sofTick,
  input wire logic defWrite,
  input wire logic csrWrite,
  input wire logic [7:0] wrData,
  input wire urdc_pkg::urdc_rx_t rxIn,
  input wire logic bufferSelectMgr,
  output urdc_pkg::urdc_def_t defReg,
  output urdc_pkg::urdc_csr_t csrReg,
  output urdc_pkg::urdc_desc_t descOut,
  output logic doneEvent,
  output logic timeoutEvent
);
  urdc_pkg::urdc_def_t def_q;
  urdc_pkg::urdc_csr_t csr_q;
  urdc_pkg::urdc_desc_t desc_q;
  urdc_pkg::urdc_state_t state_q;
  urdc_pkg::urdc_state_t state_d;
  logic [4:0] count_q;
  logic firstByte_q;
  logic done_q;
  logic toEv_q;
  localparam logic [7:0] DEF_RST = `URDC_DEF_RESET;
  localparam logic [7:0] CSR_RST = `URDC_CSR_RESET;

  wire counting = csr_q.counterEnable && def_q.enable && firstByte_q;
  wire expire = counting && sofTick && !rxIn.byteValid && (count_q == 5'h01);
  wire rxErr = def_q.enable && rxIn.rxError;
  wire burstEnd = def_q.enable && !def_q.continuous && rxIn.byteCountZero;
  // with completion irq off, timeout and error leave the channel enabled;
  // a burst that runs out always ends the transfer
  wire clearEn = (def_q.irqEnable && (expire || rxErr)) || burstEnd;
  wire halt = expire || rxErr || burstEnd;
  wire bufSel = def_q.continuous ? bufferSelectMgr : def_q.bufferSelect;
  wire swEnWr = defWrite && wrData[`URDC_DEF_EN_BIT];
  wire flagClr = csrWrite && wrData[`URDC_CSR_FLAG_BIT];

  always_comb
  begin
    state_d = state_q;
    case (state_q)
      urdc_pkg::URDC_IDLE: if (def_q.enable) state_d = urdc_pkg::URDC_RUN;
      urdc_pkg::URDC_RUN: if (halt) state_d = urdc_pkg::URDC_HALT;
      urdc_pkg::URDC_HALT: state_d = urdc_pkg::URDC_IDLE;
      default: state_d = urdc_pkg::URDC_IDLE;
    endcase
  end

  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      // protect bit and reserved bit have no storage
      def_q <= {DEF_RST[7:4], DEF_RST[2:0]};
      csr_q <= CSR_RST[7:1];
      count_q <= 5'h00;
      firstByte_q <= 1'b0;
      state_q <= urdc_pkg::URDC_IDLE;
      desc_q <= '0;
      done_q <= 1'b0;
      toEv_q <= 1'b0;
    end
    else
    begin
      state_q <= state_d;
      if (defWrite)
      begin
        def_q.enable <= wrData[`URDC_DEF_EN_BIT];
        def_q.irqEnable <= wrData[`URDC_DEF_IE_BIT];
        def_q.continuous <= wrData[`URDC_DEF_CONT_BIT];
        def_q.endpointPtr <= wrData[2:0];
        if (!wrData[`URDC_DEF_PROT_BIT])
          def_q.bufferSelect <= wrData[`URDC_DEF_BUFSEL_BIT];
      end
      else if (clearEn)
        def_q.enable <= 1'b0;
      if (csrWrite)
      begin
        csr_q.counterEnable <= wrData[`URDC_CSR_TEN_BIT];
        csr_q.timeoutValue <= wrData[`URDC_CSR_TO_MSB:`URDC_CSR_TO_LSB];
      end
      // a new timeout wins over a same-cycle clear
      if (expire)
        csr_q.timeoutFlag <= 1'b1;
      else if (flagClr || rxErr || burstEnd)
        csr_q.timeoutFlag <= flagClr ? 1'b0 : csr_q.timeoutFlag;
      if (swEnWr && !def_q.enable)
        firstByte_q <= 1'b0;
      else if (def_q.enable && rxIn.byteValid)
        firstByte_q <= 1'b1;
      if (rxIn.byteValid)
        count_q <= csr_q.timeoutValue;
      else if (counting && sofTick && count_q != 5'h00)
        count_q <= count_q - 5'h01;
      if (expire || rxErr)
        firstByte_q <= 1'b0;
      desc_q.update <= expire || rxErr || burstEnd;
      desc_q.nakClear <= expire || rxErr || burstEnd;
      desc_q.endpointPtr <= def_q.endpointPtr;
      desc_q.bufferSelect <= bufSel;
      // completion irq only on a 1-to-0 of enable, never for rx errors
      done_q <= def_q.irqEnable && clearEn && !rxErr && !defWrite;
      toEv_q <= expire;
    end
  end

  assign defReg = def_q;
  assign csrReg = csr_q;
  assign descOut = desc_q;
  assign doneEvent = done_q;
  assign timeoutEvent = toEv_q;
endmodule : urdc_channel
`default_nettype wire

//--- hw/urdc_top.sv
`timescale 1ns/10ps
`default_nettype none
`include "urdc_regs.svh"
// Operation
// - continuous mode: buffer manager drives buffer select, dma follows
// - continuous mode keeps moving data without mcu until termination
// - timeout in continuous mode halts, updates descriptor, interrupts
// - receiver error halts and updates descriptor without dma interrupt
// - irq enable 0: no completion irq, enable bit stays set on timeout or error
// - irq enable 1: interrupt on each hardware enable 1-to-0 transition except on receiver error
// - software sets enable; hardware clears it on completion or error; with irq enable 0 only a burst end clears it
// - on halt write byte count, clear nak in input descriptor
// - timeout flag set when halted by timeout
// - timeout flag cleared only by writing 1
// - timeout field reloaded into down counter on every byte
// - down counter decrements on each frame-start pulse
// - counter reaching zero sets flag and halts transfer
// - counts only with counter enable, channel enable, first byte seen
// - counter enable 0 means no timeout ever
// - burst mode stops at byte count zero or receiver error
// - buffer select: 0 is X, 1 is Y, software set in burst
module urdc_top
(
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic sofPulse,
  input wire logic [1:0] rxByteValid,
  input wire logic [1:0] rxError,
  input wire logic [1:0] rxByteCountZero,
  input wire logic [1:0] mgrBufferSelect,
  output logic [1:0] descUpdate,
  output logic [1:0] descNakClear,
  output logic [5:0] descEndpointPtr,
  output logic [1:0] descBufferSelect,
  output logic irq
);
  localparam int NCH = 2;
  logic [1:0] sofSync_q;
  logic sofPrev_q;
  logic [3:0] irqStatus_q;
  logic [3:0] irqEnable_q;
  logic irq_q;
  logic [31:0] rdata_q;
  logic ack_q;
  logic waitReq_q;
  logic [3:0] events;
  logic [7:0] defByte [NCH];
  logic [7:0] csrByte [NCH];

  // frame-start pulse arrives from another domain
  wire sofTick = sofSync_q[1] && !sofPrev_q;
  wire busReq = (avs_read || avs_write) && !ack_q;
  // writes land only at the edge that samples waitrequest low
  wire wrStb = avs_write && ack_q;

  genvar g;
  generate
    for (g = 0; g < NCH; g++)
    begin : g_ch
      urdc_pkg::urdc_def_t dr;
      urdc_pkg::urdc_csr_t cr;
      urdc_pkg::urdc_desc_t ds;
      urdc_pkg::urdc_rx_t rx;
      logic dEv;
      logic tEv;
      assign rx = '{byteValid: rxByteValid[g], rxError: rxError[g],
                    byteCountZero: rxByteCountZero[g]};
      urdc_channel u_ch
      (
        .clk(clk),
        .sys_rst(sys_rst),
        .sofTick(sofTick),
        .defWrite(wrStb && avs_address == 4'(2 * g)),
        .csrWrite(wrStb && avs_address == 4'(2 * g + 1)),
        .wrData(avs_writedata[7:0]),
        .rxIn(rx),
        .bufferSelectMgr(mgrBufferSelect[g]),
        .defReg(dr),
        .csrReg(cr),
        .descOut(ds),
        .doneEvent(dEv),
        .timeoutEvent(tEv)
      );
      assign defByte[g] = {dr.enable, dr.irqEnable, dr.continuous, dr.bufferSelect,
                           1'b1, dr.endpointPtr};
      assign csrByte[g] = {cr.counterEnable, cr.timeoutValue, cr.timeoutFlag, 1'b0};
      assign events[2 * g] = dEv;
      assign events[2 * g + 1] = tEv;
      assign descUpdate[g] = ds.update;
      assign descNakClear[g] = ds.nakClear;
      assign descEndpointPtr[3 * g +: 3] = ds.endpointPtr;
      assign descBufferSelect[g] = ds.bufferSelect;
    end
  endgenerate

  wire [3:0] irqClr = (wrStb && avs_address == `URDC_IRQ_CLEAR_ADDR) ?
                      avs_writedata[3:0] : 4'h0;
  logic [7:0] rdSel;
  always_comb
  begin
    case (avs_address)
      `URDC_CH0_DEF_ADDR: rdSel = defByte[0];
      `URDC_CH0_CSR_ADDR: rdSel = csrByte[0];
      `URDC_CH1_DEF_ADDR: rdSel = defByte[1];
      `URDC_CH1_CSR_ADDR: rdSel = csrByte[1];
      `URDC_IRQ_STATUS_ADDR: rdSel = {4'h0, irqStatus_q};
      `URDC_IRQ_ENABLE_ADDR: rdSel = {4'h0, irqEnable_q};
      default: rdSel = 8'h00;
    endcase
  end

  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      sofSync_q <= 2'h0;
      sofPrev_q <= 1'b0;
      irqStatus_q <= 4'h0;
      irqEnable_q <= 4'h0;
      irq_q <= 1'b0;
      rdata_q <= 32'h0;
      ack_q <= 1'b0;
      waitReq_q <= 1'b1;
    end
    else
    begin
      sofSync_q <= {sofSync_q[0], sofPulse};
      sofPrev_q <= sofSync_q[1];
      // events win over a same-cycle clear
      irqStatus_q <= (irqStatus_q & ~irqClr) | events;
      if (wrStb && avs_address == `URDC_IRQ_ENABLE_ADDR)
        irqEnable_q <= avs_writedata[3:0];
      irq_q <= |(((irqStatus_q & ~irqClr) | events) & irqEnable_q);
      ack_q <= busReq;
      waitReq_q <= !busReq;
      if (busReq && avs_read)
        rdata_q <= {24'h0, rdSel};
    end
  end

  // one wait cycle per access: answer flopped, read data ready alongside
  assign avs_waitrequest = waitReq_q;
  assign avs_readdata = rdata_q;
  assign irq = irq_q;
endmodule : urdc_top
`default_nettype wire

//--- tb/urdc_monitor.sv
`timescale 1ns/10ps
`default_nettype none
module urdc_monitor
(
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic avs_waitrequest,
  input wire logic [31:0] avs_readdata,
  input wire logic sofPulse,
  input wire logic [1:0] rxByteValid,
  input wire logic [1:0] rxError,
  input wire logic [1:0] rxByteCountZero,
  input wire logic [1:0] descUpdate,
  input wire logic [1:0] descNakClear,
  input wire logic irq
);
  // no halt cause on that channel; eight calm cycles cover the tick synchroniser
  wire logic [1:0] calm = ~(rxByteValid | rxError | rxByteCountZero | {2{sofPulse | avs_write}});
  default clocking @(posedge clk);
  endclocking
  default disable iff (sys_rst);
  property p_ack;
    $rose(avs_read || avs_write) |=> !avs_waitrequest;
  endproperty
  a_ack: assert property (p_ack) else $error("request not answered");
  property p_once;
    !avs_waitrequest |=> avs_waitrequest;
  endproperty
  a_once: assert property (p_once) else $error("waitrequest low too long");
  property p_cause;
    !avs_waitrequest |-> avs_read || avs_write;
  endproperty
  a_cause: assert property (p_cause) else $error("answer without request");
  property p_hold;
    !avs_read && !$past(avs_read) |-> $stable(avs_readdata);
  endproperty
  a_hold: assert property (p_hold) else $error("readdata moved");
  property p_nak;
    descUpdate != 2'h0 |-> descNakClear == descUpdate;
  endproperty
  a_nak: assert property (p_nak) else $error("nak not cleared");
  property p_calm0;
    calm[0] [*8] |=> !descUpdate[0];
  endproperty
  a_calm0: assert property (p_calm0) else $error("ch0 halt without cause");
  property p_calm1;
    calm[1] [*8] |=> !descUpdate[1];
  endproperty
  a_calm1: assert property (p_calm1) else $error("ch1 halt without cause");
  property p_irq;
    (calm == 2'h3) [*8] |=> $stable(irq);
  endproperty
  a_irq: assert property (p_irq) else $error("irq moved without cause");
endmodule : urdc_monitor
bind urdc_top urdc_monitor mon_u (.clk, .sys_rst, .avs_read, .avs_write, .avs_waitrequest,
  .avs_readdata, .sofPulse, .rxByteValid, .rxError, .rxByteCountZero, .descUpdate,
  .descNakClear, .irq);
`default_nettype wire

//--- tb/urdc_partner.sv
`timescale 1ns/10ps
`default_nettype none
module urdc_partner
(
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic [1:0] descUpdate,
  output logic sofPulse,
  output logic [1:0] mgrBufferSelect
);
  logic [5:0] sofCnt_q;
  // frame period cut to 40 clocks so timeouts fit the run
  assign sofPulse = sofCnt_q < 6'h04;
  always_ff @(posedge clk or posedge sys_rst)
    if (sys_rst)
    begin
      sofCnt_q <= 6'h10;
      mgrBufferSelect <= 2'h0;
    end
    else
    begin
      sofCnt_q <= (sofCnt_q == 6'h27) ? 6'h00 : sofCnt_q + 6'h01;
      mgrBufferSelect <= mgrBufferSelect ^ descUpdate;
    end
endmodule : urdc_partner
`default_nettype wire

//--- tb/urdc_top_tb.sv
`timescale 1ns/10ps
`default_nettype none
module urdc_top_tb;
  logic clk, sys_rst, avs_read, avs_write, avs_waitrequest, sofPulse, irq;
  logic [3:0] avs_address;
  logic [31:0] avs_writedata, avs_readdata;
  logic [1:0] rxByteValid, rxError, rxByteCountZero, mgrBufferSelect;
  logic [1:0] descUpdate, descNakClear, descBufferSelect;
  logic [5:0] descEndpointPtr;
  logic [7:0] expQ[$];
  logic [2:0] p, q;
  int n_fail, n_checks;
  urdc_top dut_u (.clk, .sys_rst, .avs_address, .avs_read, .avs_write, .avs_writedata,
    .avs_readdata, .avs_waitrequest, .sofPulse, .rxByteValid, .rxError, .rxByteCountZero,
    .mgrBufferSelect, .descUpdate, .descNakClear, .descEndpointPtr, .descBufferSelect, .irq);
  urdc_partner far_u (.clk, .sys_rst, .descUpdate, .sofPulse, .mgrBufferSelect);
  always #25 clk = ~clk;
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("unexpected %s: expected %h, seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic final_report();
    $display("checks %0d, mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : final_report
  task automatic bus(input logic w, input logic [3:0] a, input logic [7:0] d);
    int n;
    @(posedge clk);
    avs_address <= a;
    avs_writedata <= {24'h0, d};
    avs_write <= w;
    avs_read <= !w;
    n = 0;
    // waitrequest is flopped, so here it still shows what this edge samples
    do
      @(posedge clk);
    while (avs_waitrequest !== 1'b0 && ++n < 40);
    if (n >= 40)
    begin
      n_fail++;
      final_report();
    end
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask : bus
  task automatic rd(input logic [3:0] a, input logic [7:0] e);
    expQ.push_back(e);
    bus(1'b0, a, 8'h00);
  endtask : rd
  // k: 0 byte moved, 1 receiver error, 2 byte count zero
  task automatic rx(input int k, input int ch);
    @(posedge clk);
    rxByteValid[ch] <= (k == 0);
    rxError[ch] <= (k == 1);
    rxByteCountZero[ch] <= (k == 2);
    @(posedge clk);
    {rxByteValid, rxError, rxByteCountZero} <= 6'h00;
  endtask : rx
  // read data is taken at the edge that samples waitrequest low
  always @(posedge clk)
    if (avs_read === 1'b1 && avs_waitrequest === 1'b0)
      chk("readdata", avs_readdata, {24'h0, expQ.pop_front()});
  initial
  begin
    clk = 1'b0;
    sys_rst = 1'b1;
    {avs_read, avs_write, avs_address, avs_writedata} = '0;
    {rxByteValid, rxError, rxByteCountZero} = 6'h00;
    n_fail = 0;
    n_checks = 0;
    void'($urandom(32'h07af));
    p = 3'($urandom_range(7));
    q = 3'($urandom_range(7));
    repeat (5) @(posedge clk);
    sys_rst <= 1'b0;
    rd(4'h0, 8'h08);
    rd(4'h3, 8'h00);
    rd(4'h7, 8'h00);
    rd(4'h6, 8'h00);
    bus(1'b1, 4'h0, {5'h02, p});
    rd(4'h0, {5'h03, p});
    bus(1'b1, 4'h0, {5'h01, p});
    rd(4'h0, {5'h03, p});
    bus(1'b1, 4'h5, 8'h00);
    bus(1'b1, 4'h0, {5'h18, p});
    rx(0, 0);
    rx(2, 0);
    repeat (4) @(negedge clk);
    rd(4'h0, {5'h09, p});
    rd(4'h4, 8'h01);
    @(negedge clk);
    chk("irq", {31'h0, irq}, 32'h0);
    bus(1'b1, 4'h5, 8'h0f);
    repeat (4) @(negedge clk);
    chk("irq", {31'h0, irq}, 32'h1);
    bus(1'b1, 4'h6, 8'h01);
    repeat (4) @(negedge clk);
    chk("irq", {31'h0, irq}, 32'h0);
    bus(1'b1, 4'h0, {5'h18, p});
    rx(0, 0);
    rx(1, 0);
    repeat (4) @(negedge clk);
    rd(4'h0, {5'h09, p});
    rd(4'h4, 8'h00);
    bus(1'b1, 4'h1, 8'h08);
    bus(1'b1, 4'h0, {5'h14, p});
    // never a zero timeout while the counter is on
    bus(1'b1, 4'h3, 8'h88);
    bus(1'b1, 4'h2, {5'h14, q});
    repeat (200) @(posedge clk);
    rd(4'h3, 8'h88);
    // byte gaps stay under one frame so the count of two never runs out
    repeat (10)
    begin
      rx(0, 1);
      rx(0, 0);
      repeat ($urandom_range(15)) @(posedge clk);
    end
    rd(4'h3, 8'h88);
    repeat (200) @(posedge clk);
    rd(4'h3, 8'h8a);
    rd(4'h1, 8'h08);
    rd(4'h2, {5'h15, q});
    rd(4'h4, 8'h08);
    @(negedge clk);
    // ch0 saw two descriptor updates, ch1 one: the manager toggled accordingly
    chk("bufferSelect", {30'h0, descBufferSelect}, 32'h2);
    chk("endpointPtr", {26'h0, descEndpointPtr}, {26'h0, q, p});
    bus(1'b1, 4'h3, 8'h88);
    rd(4'h3, 8'h8a);
    bus(1'b1, 4'h3, 8'h8a);
    rd(4'h3, 8'h88);
    // second reset in mid-run brings both channels back to idle
    @(posedge clk);
    sys_rst <= 1'b1;
    repeat (5) @(posedge clk);
    sys_rst <= 1'b0;
    rd(4'h2, 8'h08);
    rd(4'h3, 8'h00);
    rd(4'h4, 8'h00);
    @(negedge clk);
    chk("irq", {31'h0, irq}, 32'h0);
    repeat (4) @(negedge clk);
    final_report();
  end
endmodule : urdc_top_tb
`default_nettype wire
